// >>> pkg/afesr_pkg.sv
// Shared constants and types for the front-end access and sync routing block
`default_nettype none
package afesr_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_PORT_CTRL = 4'h0;
	localparam logic [3:0] ADR_PORT_DATA = 4'h4;
	localparam logic [3:0] ADR_SYNC_CTRL = 4'h8;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_DIR_BIT = 8;
	localparam int CTRL_START_BIT = 9;
	localparam int DATA_BUSY_BIT = 8;
	localparam int DATA_ERR_BIT = 9;
	localparam int DATA_CLR_BIT = 10;
	localparam int SYNC_LIVE_BIT = 0;
	localparam int SYNC_FIRST_BIT = 1;
	localparam int SYNC_WEN_BIT = 2;
	localparam int SYNC_HD_BIT = 4;
	localparam int SYNC_VD_BIT = 5;
	localparam int SYNC_SWAP_BIT = 6;
	localparam int SYNC_INV_BIT = 7;
	localparam int SYNC_SOE_LO = 8;
	localparam int SYNC_IV_BIT = 10;
	localparam int SYNC_FEN_LO = 11;
	localparam int SYNC_HSEL_LO = 14;
	localparam int SYNC_VSEL_LO = 17;
	localparam int SYNC_GEN_BIT = 20;
	localparam int SYNC_MSG_LO = 22;
	// ----------------------------------------------------------------
	// Source codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_OWN_GEN = 3'h1;
	localparam logic [2:0] SRC_MASTER_GEN = 3'h2;
	localparam logic [2:0] SRC_CAM_LINE = 3'h3;
	localparam logic [2:0] SRC_FRONTEND = 3'h4;
	localparam logic [2:0] FEN_FROM_AFE_VD = 3'h0;
	localparam logic [2:0] FEN_FROM_WEN = 3'h1;
	localparam logic [2:0] RST_SEL = 3'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_PAIR = 2'h0;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int AFE_TIMEOUT_NS = 10000;
	localparam int AFE_TIMEOUT_CYC = AFE_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int TO_W = 8;
	localparam logic [TO_W-1:0] TO_LAST = TO_W'(AFE_TIMEOUT_CYC - 1);
	// Access engine states, one-hot
	typedef enum logic [2:0] {
		ENG_IDLE = 3'b001,
		ENG_WAIT = 3'b010,
		ENG_RELEASE = 3'b100
	} afesr_eng_t;
endpackage
`default_nettype wire

// >>> pkg/afesr_port_if.sv
// Control bundle between the register bank and the front-end access engine
`default_nettype none
interface afesr_port_if;
	logic start;
	logic clear;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic busy;
	logic err;
	logic rd_done;
	logic [7:0] rdata;
	modport ctrl (output start, clear, we, addr, wdata, input busy, err, rd_done, rdata);
	modport eng (input start, clear, we, addr, wdata, output busy, err, rd_done, rdata);
endinterface
`default_nettype wire

// >>> hdl/afesr_afe_engine.sv
// Front-end register access engine: request/acknowledge handshake with timeout
`default_nettype none
module afesr_afe_engine (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bank side
	afesr_port_if.eng port,
	// Front-end pins, inputs already synchronised
	output logic afe_req,
	output logic afe_we,
	output logic [7:0] afe_addr,
	output logic [7:0] afe_wdata,
	input wire logic [7:0] afe_rdata,
	input wire logic afe_ack,
	input wire logic afe_err
);
	afesr_pkg::afesr_eng_t state_r;
	logic [afesr_pkg::TO_W-1:0] cnt_r;
	logic err_r;
	logic rd_done_r;
	logic [7:0] rdata_r;
	logic err_evt;

	assign port.busy = (state_r != afesr_pkg::ENG_IDLE);
	assign port.err = err_r;
	assign port.rd_done = rd_done_r;
	assign port.rdata = rdata_r;

	// Failed answer or timeout seen in this cycle, in either phase
	assign err_evt = (state_r == afesr_pkg::ENG_WAIT && afe_ack && afe_err)
		|| (state_r == afesr_pkg::ENG_WAIT && !afe_ack && cnt_r == afesr_pkg::TO_LAST)
		|| (state_r == afesr_pkg::ENG_RELEASE && afe_ack && cnt_r == afesr_pkg::TO_LAST);

	// Handshake sequencer; a stuck front end ends in error, never a hang
	always_ff @(posedge clk) begin
		rd_done_r <= 1'b0;
		if (rst || port.clear) begin
			state_r <= afesr_pkg::ENG_IDLE;
			afe_req <= 1'b0;
			// A failure landing with the clear still shows: the set wins
			err_r <= !rst && err_evt;
		end else begin
			case (state_r)
				afesr_pkg::ENG_IDLE: begin
					if (port.start) begin
						afe_addr <= port.addr;
						afe_we <= port.we;
						afe_wdata <= port.wdata;
						afe_req <= 1'b1;
						err_r <= 1'b0;
						state_r <= afesr_pkg::ENG_WAIT;
					end
				end
				afesr_pkg::ENG_WAIT: begin
					if (afe_ack) begin
						rdata_r <= afe_rdata;
						err_r <= afe_err;
						rd_done_r <= !afe_we && !afe_err;
						afe_req <= 1'b0;
						state_r <= afesr_pkg::ENG_RELEASE;
					end else if (cnt_r == afesr_pkg::TO_LAST) begin
						err_r <= 1'b1;
						afe_req <= 1'b0;
						state_r <= afesr_pkg::ENG_IDLE;
					end
				end
				afesr_pkg::ENG_RELEASE: begin
					if (!afe_ack) begin
						state_r <= afesr_pkg::ENG_IDLE;
					end else if (cnt_r == afesr_pkg::TO_LAST) begin
						err_r <= 1'b1;
						state_r <= afesr_pkg::ENG_IDLE;
					end
				end
				default: begin
					state_r <= afesr_pkg::ENG_IDLE;
					afe_req <= 1'b0;
				end
			endcase
		end
	end

	// Timeout counter restarts on every phase change
	always_ff @(posedge clk) begin
		if (rst || state_r == afesr_pkg::ENG_IDLE || (state_r == afesr_pkg::ENG_WAIT && afe_ack)) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Silent front end must end in error and idle
	timeout_err_a: assert property (@(posedge clk) disable iff (rst)
		(state_r == afesr_pkg::ENG_WAIT && cnt_r == afesr_pkg::TO_LAST && !afe_ack && !port.clear)
		|=> (err_r && !port.busy && !afe_req))
		else $error("timeout did not end the access with error");
endmodule
`default_nettype wire

// >>> hdl/afesr_sync_route.sv
// One sync output pin with a selectable source, registered
`default_nettype none
module afesr_sync_route (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Source select and candidates
	input wire logic [2:0] sel,
	input wire logic own_gen,
	input wire logic master_gen,
	input wire logic cam_line,
	input wire logic frontend,
	// Pin drive
	output logic pin_o,
	output logic pin_oe
);
	// Undefined and reserved codes leave the pin undriven
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_o <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			case (sel)
				afesr_pkg::SRC_OWN_GEN: begin
					pin_o <= own_gen;
					pin_oe <= 1'b1;
				end
				afesr_pkg::SRC_MASTER_GEN: begin
					pin_o <= master_gen;
					pin_oe <= 1'b1;
				end
				afesr_pkg::SRC_CAM_LINE: begin
					pin_o <= cam_line;
					pin_oe <= 1'b1;
				end
				afesr_pkg::SRC_FRONTEND: begin
					pin_o <= frontend;
					pin_oe <= 1'b1;
				end
				default: begin
					pin_o <= 1'b0;
					pin_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> hdl/afesr_top.sv
// Register bank for front-end access, field control and sync routing
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
// Overview of operation
// - Port address byte is the front-end register address of each access.
// - Direction bit 0 means read, 1 means write.
// - Writing 1 to the start bit launches one access of that direction.
// - The data byte goes to the front end on a write access.
// - A completed read places the returned byte in the data field.
// - Busy reads 1 during an access; software leaves fields alone meanwhile.
// - Error flag shows that the latest access ended badly.
// - Writing 1 to the clear bit returns the access engine to idle.
// - Bit 0 shows the live field index.
// - Bit 1 keeps the field index seen at the first captured field.
// - Bit 2 shows the live write-enable input level.
// - Bits 4 and 5 show the live horizontal and vertical sync pins.
// - Swap bit exchanges odd and even fields.
// - Invert bit flips the incoming field index polarity.
// - Start-field value 0 starts on odd field, 1 on even.
// - Interlaced bit tells acquisition that video is interlaced.
// - Frame enable comes from front-end vertical sync or write-enable input.
// - Horizontal sync output takes own, master, camera line 3 or front end.
// - Vertical sync output likewise, camera line 4 in place of line 3.
// - Generator choice bit selects standard or custom generator.
// - Two message bits steer nothing and are visible to other grabbers.
module afesr_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Front-end chip handshake
	output logic AFE_REQ,
	output logic AFE_WE,
	output logic [7:0] AFE_ADDR,
	output logic [7:0] AFE_WDATA,
	input wire logic [7:0] AFE_RDATA,
	input wire logic AFE_ACK,
	input wire logic AFE_ERR,
	input wire logic AFE_HD,
	input wire logic AFE_VD,
	// Camera side pins
	input wire logic FIELD_IDX,
	input wire logic WEN,
	input wire logic CAM_LINE_3,
	input wire logic CAM_LINE_4,
	input wire logic HD_I,
	output logic HD_O,
	output logic HD_OE,
	input wire logic VD_I,
	output logic VD_O,
	output logic VD_OE,
	// On-chip generators and acquisition engine
	input wire logic OWN_GEN_HD,
	input wire logic OWN_GEN_VD,
	input wire logic MASTER_GEN_HD,
	input wire logic MASTER_GEN_VD,
	input wire logic ACQ_FIRST_FIELD,
	input wire logic [1:0] PEER_MSG,
	// Acquisition controls
	output logic FRAME_EN,
	output logic FIELD_OUT,
	output logic START_FIELD_OK,
	output logic INTERLACED,
	output logic GEN_CUSTOM,
	output logic [1:0] MSG_OUT
);
	afesr_port_if port ();

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int PIN_W = 18;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_m_r;
	logic [PIN_W-1:0] pin_s_r;
	logic [7:0] afe_rdata_s;
	logic afe_ack_s;
	logic afe_err_s;
	logic fi_s;
	logic wen_s;
	logic hd_s;
	logic vd_s;
	logic afe_hd_s;
	logic afe_vd_s;
	logic cam3_s;
	logic cam4_s;

	assign pin_raw = {AFE_RDATA, AFE_ACK, AFE_ERR, FIELD_IDX, WEN, HD_I, VD_I,
		AFE_HD, AFE_VD, CAM_LINE_3, CAM_LINE_4};
	assign {afe_rdata_s, afe_ack_s, afe_err_s, fi_s, wen_s, hd_s, vd_s,
		afe_hd_s, afe_vd_s, cam3_s, cam4_s} = pin_s_r;

	// Two stages; only the second is read by any logic
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pin_m_r <= '0;
			pin_s_r <= '0;
		end else begin
			pin_m_r <= pin_raw;
			pin_s_r <= pin_m_r;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone access decode
	// ----------------------------------------------------------------
	logic acc;
	logic wr;
	logic wr_ctrl;
	logic wr_data;
	logic wr_sync;

	assign acc = WB_CYC_I && WB_STB_I;
	// Writes land on the edge where the master samples ack
	assign wr = acc && WB_ACK_O && WB_WE_I;
	assign wr_ctrl = wr && (WB_ADR_I == afesr_pkg::ADR_PORT_CTRL);
	assign wr_data = wr && (WB_ADR_I == afesr_pkg::ADR_PORT_DATA);
	assign wr_sync = wr && (WB_ADR_I == afesr_pkg::ADR_SYNC_CTRL);

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= acc && !WB_ACK_O;
		end
	end

	// ----------------------------------------------------------------
	// Front-end port registers
	// ----------------------------------------------------------------
	logic [7:0] addr_r;
	logic dir_r;
	logic [7:0] data_r;
	logic start_r;
	logic clear_r;

	assign port.addr = addr_r;
	assign port.we = dir_r;
	assign port.wdata = data_r;
	assign port.start = start_r;
	assign port.clear = clear_r;

	// Address and direction; frozen while busy so an access sees stable values
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			addr_r <= afesr_pkg::RST_BYTE;
			dir_r <= 1'b0;
		end else if (wr_ctrl && !port.busy) begin
			if (WB_SEL_I[0]) begin
				addr_r <= WB_DAT_I[7:0];
			end
			if (WB_SEL_I[1]) begin
				dir_r <= WB_DAT_I[afesr_pkg::CTRL_DIR_BIT];
			end
		end
	end

	// Data byte: software write, or the byte of a finished read
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			data_r <= afesr_pkg::RST_BYTE;
		end else if (port.rd_done) begin
			data_r <= port.rdata;
		end else if (wr_data && WB_SEL_I[0] && !port.busy) begin
			data_r <= WB_DAT_I[7:0];
		end
	end

	// Write-only strobes; a start while busy is dropped here
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			start_r <= 1'b0;
			clear_r <= 1'b0;
		end else begin
			start_r <= wr_ctrl && WB_SEL_I[1] && WB_DAT_I[afesr_pkg::CTRL_START_BIT]
				&& !port.busy && !start_r;
			clear_r <= wr_data && WB_SEL_I[1] && WB_DAT_I[afesr_pkg::DATA_CLR_BIT];
		end
	end

	afesr_afe_engine u_engine (
		.clk(CLK),
		.rst(SYS_RST),
		.port(port.eng),
		.afe_req(AFE_REQ),
		.afe_we(AFE_WE),
		.afe_addr(AFE_ADDR),
		.afe_wdata(AFE_WDATA),
		.afe_rdata(afe_rdata_s),
		.afe_ack(afe_ack_s),
		.afe_err(afe_err_s)
	);

	// ----------------------------------------------------------------
	// Sync and field control register
	// ----------------------------------------------------------------
	logic swap_r;
	logic inv_r;
	logic [1:0] soe_r;
	logic iv_r;
	logic [2:0] frame_enable_source_r;
	logic [2:0] hsel_r;
	logic [2:0] vsel_r;
	logic gen_r;
	logic [1:0] msg_r;
	logic first_r;
	logic parity_live;

	assign parity_live = fi_s ^ inv_r;

	// Writable fields, per byte lane
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			swap_r <= 1'b0;
			inv_r <= 1'b0;
			soe_r <= afesr_pkg::RST_PAIR;
			iv_r <= 1'b0;
			frame_enable_source_r <= afesr_pkg::RST_SEL;
			hsel_r <= afesr_pkg::RST_SEL;
			vsel_r <= afesr_pkg::RST_SEL;
			gen_r <= 1'b0;
			msg_r <= afesr_pkg::RST_PAIR;
		end else if (wr_sync) begin
			if (WB_SEL_I[0]) begin
				swap_r <= WB_DAT_I[afesr_pkg::SYNC_SWAP_BIT];
				inv_r <= WB_DAT_I[afesr_pkg::SYNC_INV_BIT];
			end
			if (WB_SEL_I[1]) begin
				soe_r <= WB_DAT_I[afesr_pkg::SYNC_SOE_LO +: 2];
				iv_r <= WB_DAT_I[afesr_pkg::SYNC_IV_BIT];
				frame_enable_source_r <= WB_DAT_I[afesr_pkg::SYNC_FEN_LO +: 3];
				hsel_r[1:0] <= WB_DAT_I[afesr_pkg::SYNC_HSEL_LO +: 2];
			end
			if (WB_SEL_I[2]) begin
				hsel_r[2] <= WB_DAT_I[afesr_pkg::SYNC_HSEL_LO + 2];
				vsel_r <= WB_DAT_I[afesr_pkg::SYNC_VSEL_LO +: 3];
				gen_r <= WB_DAT_I[afesr_pkg::SYNC_GEN_BIT];
				msg_r <= WB_DAT_I[afesr_pkg::SYNC_MSG_LO +: 2];
			end
		end
	end

	// First-field index; the capture event wins over a software write
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			first_r <= 1'b0;
		end else if (ACQ_FIRST_FIELD) begin
			first_r <= parity_live;
		end else if (wr_sync && WB_SEL_I[0]) begin
			first_r <= WB_DAT_I[afesr_pkg::SYNC_FIRST_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Acquisition outputs
	// ----------------------------------------------------------------
	// Reserved frame-enable codes hold the frame disabled
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			FRAME_EN <= 1'b0;
		end else begin
			case (frame_enable_source_r)
				afesr_pkg::FEN_FROM_AFE_VD: FRAME_EN <= afe_vd_s;
				afesr_pkg::FEN_FROM_WEN: FRAME_EN <= wen_s;
				default: FRAME_EN <= 1'b0;
			endcase
		end
	end

	// Field seen by acquisition: low means odd after invert and swap
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			FIELD_OUT <= 1'b0;
			START_FIELD_OK <= 1'b0;
		end else begin
			FIELD_OUT <= parity_live ^ swap_r;
			START_FIELD_OK <= !iv_r || ((parity_live ^ swap_r) == soe_r[0]);
		end
	end

	// Mirrors of plain control bits
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			INTERLACED <= 1'b0;
			GEN_CUSTOM <= 1'b0;
			MSG_OUT <= afesr_pkg::RST_PAIR;
		end else begin
			INTERLACED <= iv_r;
			GEN_CUSTOM <= gen_r;
			MSG_OUT <= msg_r;
		end
	end

	// Sync output pins, one router each
	afesr_sync_route u_hd_route (
		.clk(CLK),
		.rst(SYS_RST),
		.sel(hsel_r),
		.own_gen(OWN_GEN_HD),
		.master_gen(MASTER_GEN_HD),
		.cam_line(cam3_s),
		.frontend(afe_hd_s),
		.pin_o(HD_O),
		.pin_oe(HD_OE)
	);

	afesr_sync_route u_vd_route (
		.clk(CLK),
		.rst(SYS_RST),
		.sel(vsel_r),
		.own_gen(OWN_GEN_VD),
		.master_gen(MASTER_GEN_VD),
		.cam_line(cam4_s),
		.frontend(afe_vd_s),
		.pin_o(VD_O),
		.pin_oe(VD_OE)
	);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [31:0] rd_word;

	// Write-only and reserved bits read zero
	always_comb begin
		rd_word = '0;
		case (WB_ADR_I)
			afesr_pkg::ADR_PORT_CTRL: begin
				rd_word[7:0] = addr_r;
				rd_word[afesr_pkg::CTRL_DIR_BIT] = dir_r;
			end
			afesr_pkg::ADR_PORT_DATA: begin
				rd_word[7:0] = data_r;
				rd_word[afesr_pkg::DATA_BUSY_BIT] = port.busy;
				rd_word[afesr_pkg::DATA_ERR_BIT] = port.err;
			end
			afesr_pkg::ADR_SYNC_CTRL: begin
				rd_word[afesr_pkg::SYNC_LIVE_BIT] = parity_live;
				rd_word[afesr_pkg::SYNC_FIRST_BIT] = first_r;
				rd_word[afesr_pkg::SYNC_WEN_BIT] = wen_s;
				rd_word[afesr_pkg::SYNC_HD_BIT] = hd_s;
				rd_word[afesr_pkg::SYNC_VD_BIT] = vd_s;
				rd_word[afesr_pkg::SYNC_SWAP_BIT] = swap_r;
				rd_word[afesr_pkg::SYNC_INV_BIT] = inv_r;
				rd_word[afesr_pkg::SYNC_SOE_LO +: 2] = soe_r;
				rd_word[afesr_pkg::SYNC_IV_BIT] = iv_r;
				rd_word[afesr_pkg::SYNC_FEN_LO +: 3] = frame_enable_source_r;
				rd_word[afesr_pkg::SYNC_HSEL_LO +: 3] = hsel_r;
				rd_word[afesr_pkg::SYNC_VSEL_LO +: 3] = vsel_r;
				rd_word[afesr_pkg::SYNC_GEN_BIT] = gen_r;
				rd_word[afesr_pkg::SYNC_MSG_LO +: 2] = msg_r | PEER_MSG;
			end
			default: rd_word = '0;
		endcase
	end

	// Read data sampled on the request edge, stands with ack
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			WB_DAT_O <= '0;
		end else if (acc && !WB_ACK_O) begin
			WB_DAT_O <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	sequence start_taken_s;
		start_r && !port.busy && !clear_r;
	endsequence

	sequence read_finish_s;
		port.rd_done ##1 1'b1;
	endsequence

	start_busy_a: assert property (start_taken_s |=> port.busy && AFE_REQ)
		else $error("accepted start did not raise busy and request");
	start_fields_a: assert property (start_taken_s |=> AFE_ADDR == $past(addr_r)
		&& AFE_WE == $past(dir_r) && AFE_WDATA == $past(data_r))
		else $error("access did not carry address, direction and data");
	busy_ignore_a: assert property (wr_ctrl && WB_DAT_I[afesr_pkg::CTRL_START_BIT]
		&& port.busy |=> !start_r && $stable(addr_r) && $stable(dir_r))
		else $error("start or address taken while busy");
	new_err_a: assert property (start_taken_s |=> !port.err)
		else $error("error flag not cleared by new access");
	read_load_a: assert property (read_finish_s |-> data_r == $past(port.rdata))
		else $error("read byte not placed in data field");
	clear_idle_a: assert property (clear_r |=> !port.busy && !AFE_REQ)
		else $error("clear did not return engine to idle");
	fen_route_a: assert property (frame_enable_source_r == afesr_pkg::FEN_FROM_WEN
		&& $stable(frame_enable_source_r) |=> FRAME_EN == $past(wen_s))
		else $error("frame enable not following write-enable");
	hd_drive_a: assert property (hsel_r == afesr_pkg::SRC_CAM_LINE
		|=> HD_OE && HD_O == $past(cam3_s))
		else $error("horizontal sync not driven from camera line");
	vd_off_a: assert property (vsel_r == afesr_pkg::RST_SEL |=> !VD_OE)
		else $error("vertical sync driven on undefined code");
	wb_ack_a: assert property (acc && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("bus ack not a single cycle after request");
endmodule
`default_nettype wire

// >>> testbench/afesr_afe_model.sv
// Behavioural front-end chip on the far side of the request handshake
`default_nettype none
module afesr_afe_model (
	// Clock and request
	input wire logic clk,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	// Answer
	output logic [7:0] rdata,
	output logic ack,
	output logic err,
	// Bench controls: stall past the block's timeout, failed answer
	input wire logic slow,
	input wire logic bad
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	int cnt;
	initial begin
		{rdata, ack, err} = 10'h0;
		cnt = 0;
	end
	// Data settles at least two cycles before ack and holds until the request drops
	always @(posedge clk) begin
		if (req !== 1'b1) begin
			ack <= 1'b0;
			cnt <= 0;
			rdata <= ~rdata; // Released bus, no stale byte
			err <= ~err;
		end else if (!ack) begin
			cnt <= cnt + 1;
			if (cnt == 1) begin
				rdata <= we ? ~wdata : mem[addr];
				err <= bad;
				if (we && !bad) begin
					mem[addr] <= wdata;
				end
			end
			if (cnt == (slow ? 250 : 3)) begin
				ack <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> testbench/afesr_top_tb_top.sv
// Self-checking bench for the front-end access and sync routing block
`default_nettype none
module afesr_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK, SYS_RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, AFE_REQ, AFE_WE;
	logic [3:0] WB_ADR_I, WB_SEL_I;
	logic [31:0] WB_DAT_I, WB_DAT_O, q;
	logic [7:0] AFE_ADDR, AFE_WDATA, AFE_RDATA;
	logic AFE_ACK, AFE_ERR, AFE_HD, AFE_VD, FIELD_IDX, WEN, CAM_LINE_3, CAM_LINE_4;
	logic HD_O, HD_OE, VD_O, VD_OE, OWN_GEN_HD, OWN_GEN_VD, MASTER_GEN_HD, MASTER_GEN_VD;
	logic ACQ_FIRST_FIELD, FRAME_EN, FIELD_OUT, START_FIELD_OK, INTERLACED, GEN_CUSTOM;
	logic slow, bad, ext;
	logic [1:0] PEER_MSG, MSG_OUT, eh, ev;
	int error_cnt = 0;
	int comparisons = 0;
	// Pin level: the block when enabled, else the far party
	wire HD_I = HD_OE ? HD_O : ext;
	wire VD_I = VD_OE ? VD_O : ext;
	afesr_top dut (.CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
		.WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .AFE_REQ, .AFE_WE, .AFE_ADDR, .AFE_WDATA,
		.AFE_RDATA, .AFE_ACK, .AFE_ERR, .AFE_HD, .AFE_VD, .FIELD_IDX, .WEN, .CAM_LINE_3,
		.CAM_LINE_4, .HD_I, .HD_O, .HD_OE, .VD_I, .VD_O, .VD_OE, .OWN_GEN_HD, .OWN_GEN_VD,
		.MASTER_GEN_HD, .MASTER_GEN_VD, .ACQ_FIRST_FIELD, .PEER_MSG, .FRAME_EN, .FIELD_OUT,
		.START_FIELD_OK, .INTERLACED, .GEN_CUSTOM, .MSG_OUT);
	afesr_afe_model fe_chip (.clk(CLK), .req(AFE_REQ), .we(AFE_WE), .addr(AFE_ADDR),
		.wdata(AFE_WDATA), .rdata(AFE_RDATA), .ack(AFE_ACK), .err(AFE_ERR), .slow, .bad);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("comparisons %0d, error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	// One classic cycle, held until ack is seen
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge CLK);
		{WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, w, a, d};
		do begin
			@(posedge CLK);
			n++;
		end while (WB_ACK_O !== 1'b1 && n < 20);
		r = WB_DAT_O;
		{WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'b000;
		if (n == 20) begin
			error_cnt++;
			$display("wrong value at %0t: no bus ack", $time);
			test_done();
		end
	endtask
	// Start one access, then poll busy; software leaves fields alone meanwhile
	task automatic fe(input logic w, input logic [7:0] a, output logic [31:0] r);
		int n;
		wb(1'b1, 4'h0, {22'h0, 1'b1, w, a}, r);
		repeat (3) @(posedge CLK);
		chk({AFE_REQ, AFE_WE, AFE_ADDR}, {1'b1, w, a});
		n = 0;
		do begin
			wb(1'b0, 4'h4, 32'h0, r);
			n++;
		end while (r[8] !== 1'b0 && n < 100);
		chk(n > 1, 1'b1);
		if (n == 100) begin
			error_cnt++;
			$display("wrong value at %0t: busy never ended", $time);
			test_done();
		end
	endtask
	function automatic logic [1:0] pin(input logic [2:0] s, input logic [3:0] src);
		case (s)
			afesr_pkg::SRC_OWN_GEN: pin = {1'b1, src[3]};
			afesr_pkg::SRC_MASTER_GEN: pin = {1'b1, src[2]};
			afesr_pkg::SRC_CAM_LINE: pin = {1'b1, src[1]};
			afesr_pkg::SRC_FRONTEND: pin = {1'b1, src[0]};
			default: pin = 2'b00;
		endcase
	endfunction
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	initial begin
		{SYS_RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} = {1'b1, 39'h0};
		WB_SEL_I = 4'hf;
		{AFE_HD, AFE_VD, FIELD_IDX, WEN, CAM_LINE_3, CAM_LINE_4, OWN_GEN_HD} = 7'h0;
		{OWN_GEN_VD, MASTER_GEN_HD, MASTER_GEN_VD, ACQ_FIRST_FIELD, PEER_MSG} = 6'h0;
		{slow, bad, ext} = 3'h0;
		repeat (2) @(posedge CLK);
		SYS_RST <= 1'b0;
		// Reset values, unmapped place included
		for (int a = 0; a < 16; a += 4) begin
			wb(1'b0, a[3:0], 32'h0, q);
			chk(q, 32'h0);
		end
		$display("reset values done");
		wb(1'b1, 4'h4, 32'ha5, q);
		fe(1'b1, 8'h3c, q);
		chk(q, 32'ha5);
		chk({AFE_WDATA, fe_chip.mem[8'h3c]}, 16'ha5a5);
		wb(1'b1, 4'h4, 32'h0, q);
		fe(1'b0, 8'h3c, q);
		chk(q, 32'ha5);
		bad <= 1'b1;
		fe(1'b0, 8'h3c, q);
		chk(q, 32'h2a5);
		bad <= 1'b0;
		fe(1'b0, 8'h3c, q);
		chk(q, 32'ha5);
		$display("port access done");
		// Stalled access: second start ignored, clear aborts it
		slow <= 1'b1;
		wb(1'b1, 4'h0, 32'h311, q);
		repeat (3) @(posedge CLK);
		wb(1'b1, 4'h0, 32'h322, q);
		chk(AFE_ADDR, 8'h11);
		wb(1'b0, 4'h4, 32'h0, q);
		chk(q[9:8], 2'b01);
		wb(1'b1, 4'h4, 32'h400, q);
		wb(1'b0, 4'h4, 32'h0, q);
		chk({q[9:8], AFE_REQ}, 3'b000);
		wb(1'b0, 4'h0, 32'h0, q);
		chk(q, 32'h111);
		// Silent front end: the engine gives up with the error flag
		fe(1'b0, 8'h3c, q);
		chk(q, 32'h2a5);
		slow <= 1'b0;
		$display("abort done");
		// Every source code of both sync pins and the frame enable
		for (int s = 0; s < 8; s++) begin
			for (int v = 0; v < 2; v++) begin
				wb(1'b1, 4'h8, {12'h0, {3{s[2:0]}}, 11'h0}, q);
				{OWN_GEN_HD, MASTER_GEN_HD, CAM_LINE_3, AFE_HD} <= v[0] ? 4'ha : 4'h5;
				{OWN_GEN_VD, MASTER_GEN_VD, CAM_LINE_4, AFE_VD} <= v[0] ? 4'h5 : 4'ha;
				{WEN, ext} <= {~v[0], v[0]};
				repeat (6) @(posedge CLK);
				eh = pin(s[2:0], v[0] ? 4'ha : 4'h5);
				ev = pin(s[2:0], v[0] ? 4'h5 : 4'ha);
				chk({HD_OE, HD_O & HD_OE}, eh);
				chk({VD_OE, VD_O & VD_OE}, ev);
				chk(FRAME_EN, s == 0 ? v[0] : s == 1 ? !v[0] : 1'b0);
				wb(1'b0, 4'h8, 32'h0, q);
				chk(q[19:0], {{3{s[2:0]}}, 5'h0, ev[1] ? ev[0] : v[0],
					eh[1] ? eh[0] : v[0], 1'b0, ~v[0], 2'b0});
			end
		end
		$display("routing done");
		// Field index handling over all settings
		for (int k = 0; k < 32; k++) begin
			wb(1'b1, 4'h8, {21'h0, k[4], 1'b0, k[3:1], 6'h0}, q);
			FIELD_IDX <= k[0];
			repeat (5) @(posedge CLK);
			chk(FIELD_OUT, k[0] ^ k[1] ^ k[2]);
			chk(START_FIELD_OK, !k[4] || (k[0] ^ k[1] ^ k[2]) == k[3]);
			chk(INTERLACED, k[4]);
		end
		$display("field control done");
		FIELD_IDX <= 1'b1;
		PEER_MSG <= 2'b10;
		wb(1'b1, 4'h8, 32'h500000, q);
		repeat (4) @(posedge CLK);
		ACQ_FIRST_FIELD <= 1'b1;
		@(posedge CLK);
		ACQ_FIRST_FIELD <= 1'b0;
		wb(1'b0, 4'h8, 32'h0, q);
		chk({GEN_CUSTOM, MSG_OUT}, 3'b101);
		chk({q[23:20], q[1:0]}, 6'b110111);
		$display("capture and message done");
		test_done();
	end
endmodule
`default_nettype wire
